// File: uifc_pkg.sv
// constants, types and helpers shared by the interrupt and queue control block
package uifc_pkg;

  // ---------------------------------------------------------------
  // register offsets on the parallel register port
  // ---------------------------------------------------------------
  localparam logic [2:0] OFS_RXTX    = 3'h0;
  localparam logic [2:0] OFS_IER     = 3'h1;
  localparam logic [2:0] OFS_ISR_FCR = 3'h2;
  localparam logic [2:0] OFS_LSR     = 3'h5;
  localparam logic [2:0] OFS_MSR     = 3'h6;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int IER_RXD   = 0;
  localparam int IER_TXR   = 1;
  localparam int IER_LSR   = 2;
  localparam int IER_MDM   = 3;
  localparam int IER_SLEEP = 4;
  localparam int IER_XOFF  = 5;
  localparam int IER_RTS   = 6;
  localparam int IER_CTS   = 7;
  localparam int QC_EN     = 0;
  localparam int QC_RXRST  = 1;
  localparam int QC_TXRST  = 2;
  localparam int QC_WAKE   = 3;

  localparam logic [7:0] IER_RST   = 8'h00;
  localparam logic [1:0] TRIG_RST  = 2'h0;
  localparam logic [6:0] SRC_NONE  = 7'h00;

  localparam int LEVEL_W = 6;

  // ---------------------------------------------------------------
  // source indices, highest priority first, and status codes
  // ---------------------------------------------------------------
  localparam int SRC_LSR  = 0;
  localparam int SRC_TMO  = 1;
  localparam int SRC_RXD  = 2;
  localparam int SRC_TXR  = 3;
  localparam int SRC_MDM  = 4;
  localparam int SRC_FLOW = 5;
  localparam int SRC_HWFC = 6;
  localparam int SRC_N    = 7;

  localparam logic [5:0] CODE_LSR  = 6'h06;
  localparam logic [5:0] CODE_TMO  = 6'h0c;
  localparam logic [5:0] CODE_RXD  = 6'h04;
  localparam logic [5:0] CODE_TXR  = 6'h02;
  localparam logic [5:0] CODE_MDM  = 6'h00;
  localparam logic [5:0] CODE_FLOW = 6'h10;
  localparam logic [5:0] CODE_HWFC = 6'h20;
  localparam logic [5:0] CODE_NONE = 6'h01;

  // ---------------------------------------------------------------
  // receive timeout: characters and extra bit times
  // ---------------------------------------------------------------
  localparam logic [6:0] TO_CHARS      = 7'h04;
  localparam logic [6:0] TO_EXTRA_BITS = 7'h0c;

  typedef enum logic [1:0] {TO_IDLE, TO_RUN, TO_DONE} uifc_to_state_t;

  function automatic logic [LEVEL_W-1:0] rx_trig_lvl(input logic [1:0] sel);
    unique case (sel)
      2'h0: rx_trig_lvl = 6'h08;
      2'h1: rx_trig_lvl = 6'h10;
      2'h2: rx_trig_lvl = 6'h18;
      2'h3: rx_trig_lvl = 6'h1c;
    endcase
  endfunction

  function automatic logic [LEVEL_W-1:0] tx_trig_lvl(input logic [1:0] sel);
    unique case (sel)
      2'h0: tx_trig_lvl = 6'h10;
      2'h1: tx_trig_lvl = 6'h08;
      2'h2: tx_trig_lvl = 6'h18;
      2'h3: tx_trig_lvl = 6'h1e;
    endcase
  endfunction

endpackage

// File: uifc_prio.sv
// priority encoder from pending sources to status code
`timescale 1ns/1ps
`default_nettype none
module uifc_prio
  import uifc_pkg::*;
(
  input  wire logic [SRC_N-1:0] act,
  output logic      [5:0]       code
);

  // ---------------------------------------------------------------
  // lowest index wins; nothing pending gives the idle code
  // ---------------------------------------------------------------
  always_comb begin
    code = CODE_NONE;
    if (act[SRC_LSR]) begin
      code = CODE_LSR;
    end else if (act[SRC_TMO]) begin
      code = CODE_TMO;
    end else if (act[SRC_RXD]) begin
      code = CODE_RXD;
    end else if (act[SRC_TXR]) begin
      code = CODE_TXR;
    end else if (act[SRC_MDM]) begin
      code = CODE_MDM;
    end else if (act[SRC_FLOW]) begin
      code = CODE_FLOW;
    end else if (act[SRC_HWFC]) begin
      code = CODE_HWFC;
    end
  end

endmodule
`default_nettype wire

// File: uifc_timeout.sv
// receive timeout timer counted in bit times
`timescale 1ns/1ps
`default_nettype none
module uifc_timeout
  import uifc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       bit_tick,
  input  wire logic [3:0] char_bits,
  input  wire logic       rx_nonempty,
  input  wire logic       activity,
  output logic            fire
);

  uifc_to_state_t state_reg;
  logic [6:0]     cnt_reg;
  logic [6:0]     limit;

  assign limit = 7'(TO_CHARS * {3'h0, char_bits}) + TO_EXTRA_BITS;
  // no fire once the fifo has drained or a push or pop restarts the count
  assign fire  = (state_reg == TO_RUN) && bit_tick && rx_nonempty && !activity &&
                 (cnt_reg == limit - 7'h01);

  // ---------------------------------------------------------------
  // restart on every push or pop, fire once per idle stretch
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= TO_IDLE;
      cnt_reg   <= 7'h00;
    end else if (activity || !rx_nonempty) begin
      state_reg <= rx_nonempty ? TO_RUN : TO_IDLE;
      cnt_reg   <= 7'h00;
    end else begin
      unique case (state_reg)
        TO_IDLE: state_reg <= TO_RUN;
        TO_RUN: begin
          if (fire) begin
            state_reg <= TO_DONE;
          end else if (bit_tick) begin
            cnt_reg <= cnt_reg + 7'h01;
          end
        end
        TO_DONE: state_reg <= TO_DONE;
      endcase
    end
  end

  a_timeout_count: assert property (@(posedge clk) disable iff (!rst_b)
    fire |-> (cnt_reg == limit - 7'h01) && bit_tick && rx_nonempty)
    else $error("timeout fired at wrong count");

endmodule
`default_nettype wire

// File: uifc_ctrl.sv
// interrupt enable, prioritised interrupt status and queue control
//
// Functional notes
// - fifos on and enables 3:0 clear: polled mode, status bits still readable
// - line status bit0 data present, bit1 overrun, bits4:2 head error, bit7 any error
// - line status bit5 holding empty, bit6 fifo and shifter both empty
// - enable bit0: receive data interrupt on character or trigger level
// - enable bit1: transmit ready on empty or below trigger, immediate if empty
// - enable bit2: line status interrupt on overrun or head character error
// - enhanced mode bit6: error interrupt as character enters the fifo
// - enable bit3: modem interrupt from deltas 3:0, cleared by modem status read
// - enable bits 7:4 writable and effective only with enhanced enable; reset zero
// - enable bit6 with auto rts: interrupt on rts low to high
// - enable bit7 with auto cts: interrupt on cts low to high
// - status read reports highest source only, others stay queued
// - fixed six bit codes per source, priorities one to seven
// - receive timeout after four characters plus twelve bits, cleared by data read
// - transmit ready cleared by status read or holding write
// - receive data clears below trigger; line status clears on its read
// - flow char clears on status read; special char also on next character
// - rts and cts change interrupts clear on modem status read
// - wake-up reported with idle code, cleared on status read
// - status bit0 low when pending; bits 7:6 show fifo enable
// - queue control bit0 enables fifos; other bits ignored without it
// - queue control bits 2:1 reset fifo pointers and self clear
// - receive trigger 8, 16, 24, 28 from bits 7:6
// - transmit trigger 16, 8, 24, 30 from bits 5:4, enhanced only
`timescale 1ns/1ps
`default_nettype none
module uifc_ctrl
  import uifc_pkg::*;
(
  input  wire logic               MCLK,
  input  wire logic               RST_B,
  input  wire logic [2:0]         ADDR,
  input  wire logic               RD_STB,
  input  wire logic               WR_STB,
  input  wire logic [7:0]         WR_DATA,
  output logic      [7:0]         RD_DATA,
  input  wire logic [7:0]         RHR_DATA,
  input  wire logic [3:0]         MODEM_LINES,
  input  wire logic [3:0]         MODEM_DELTA,
  input  wire logic [LEVEL_W-1:0] RX_LEVEL,
  input  wire logic [LEVEL_W-1:0] TX_LEVEL,
  input  wire logic               TSR_EMPTY,
  input  wire logic [2:0]         RX_HEAD_ERR,
  input  wire logic               RX_PUSH,
  input  wire logic [2:0]         RX_PUSH_ERR,
  input  wire logic               RX_OVERRUN,
  input  wire logic               RX_FIFO_ERR,
  input  wire logic               FLOW_CHAR_MATCH,
  input  wire logic               SPECIAL_MATCH,
  input  wire logic               WAKE_EVENT,
  input  wire logic               BIT_TICK,
  input  wire logic [3:0]         CHAR_BITS,
  input  wire logic               ENH_ENABLE,
  input  wire logic               ENH_LSR_EARLY,
  input  wire logic               AUTO_RTS_EN,
  input  wire logic               AUTO_CTS_EN,
  input  wire logic               RTS_STATE,
  input  wire logic               CTS_N,
  output logic                    INT,
  output logic                    FIFO_EN,
  output logic                    RX_FIFO_RST,
  output logic                    TX_FIFO_RST,
  output logic                    RX_POP,
  output logic      [LEVEL_W-1:0] RX_TRIG,
  output logic      [LEVEL_W-1:0] TX_TRIG,
  output logic                    SLEEP_EN
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic rd_rhr, rd_isr, rd_lsr, rd_msr, wr_ier, wr_qc, wr_thr;
  assign rd_rhr = RD_STB && (ADDR == OFS_RXTX);
  assign rd_isr = RD_STB && (ADDR == OFS_ISR_FCR);
  assign rd_lsr = RD_STB && (ADDR == OFS_LSR);
  assign rd_msr = RD_STB && (ADDR == OFS_MSR);
  assign wr_thr = WR_STB && (ADDR == OFS_RXTX);
  assign wr_ier = WR_STB && (ADDR == OFS_IER);
  assign wr_qc  = WR_STB && (ADDR == OFS_ISR_FCR);

  // ---------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------
  logic [7:0] ier_reg;
  logic [7:0] ier_eff;
  logic       wake_en_reg;
  logic       ovr_reg, herr_reg, tmo_reg, tx_reg, flow_reg, spec_reg;
  logic       hwfc_reg, wake_reg;
  logic [3:0] mdelta_reg;
  logic       tx_low_q, tx_empty_q, txen_q, rts_q, cts_q;
  logic [1:0] cts_sync_reg;
  logic [SRC_N-1:0] act;
  logic [5:0] code;
  logic       tmo_fire;

  // ier bits 7:4 have no effect unless enhanced functions are on
  assign ier_eff = ENH_ENABLE ? ier_reg : {4'h0, ier_reg[3:0]};

  // ---------------------------------------------------------------
  // enable register
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ier_reg <= IER_RST;
    end else if (wr_ier) begin
      ier_reg[3:0] <= WR_DATA[3:0];
      if (ENH_ENABLE) begin
        ier_reg[7:4] <= WR_DATA[7:4];
      end
    end
  end

  // ---------------------------------------------------------------
  // queue control
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      FIFO_EN     <= 1'b0;
      RX_TRIG     <= rx_trig_lvl(TRIG_RST);
      TX_TRIG     <= tx_trig_lvl(TRIG_RST);
      wake_en_reg <= 1'b0;
      RX_FIFO_RST <= 1'b0;
      TX_FIFO_RST <= 1'b0;
    end else begin
      RX_FIFO_RST <= 1'b0;
      TX_FIFO_RST <= 1'b0;
      if (wr_qc) begin
        FIFO_EN <= WR_DATA[QC_EN];
        if (WR_DATA[QC_EN]) begin
          RX_FIFO_RST <= WR_DATA[QC_RXRST];
          TX_FIFO_RST <= WR_DATA[QC_TXRST];
          RX_TRIG     <= rx_trig_lvl(WR_DATA[7:6]);
          if (ENH_ENABLE) begin
            TX_TRIG     <= tx_trig_lvl(WR_DATA[5:4]);
            wake_en_reg <= WR_DATA[QC_WAKE];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // level conditions
  // ---------------------------------------------------------------
  logic rx_nonempty, rxd_lvl, tx_empty, tx_low, tx_set;
  assign rx_nonempty = (RX_LEVEL != 6'h00);
  assign rxd_lvl  = FIFO_EN ? (RX_LEVEL >= RX_TRIG) : rx_nonempty;
  assign tx_empty = (TX_LEVEL == 6'h00);
  assign tx_low   = FIFO_EN ? (TX_LEVEL < TX_TRIG) : tx_empty;
  assign tx_set   = ier_eff[IER_TXR] &&
                    ((tx_low && !tx_low_q) || (tx_empty && !tx_empty_q) || (tx_low && !txen_q));

  // ---------------------------------------------------------------
  // edge history and cts pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_low_q     <= 1'b1;
      tx_empty_q   <= 1'b1;
      txen_q       <= 1'b0;
      rts_q        <= 1'b0;
      cts_q        <= 1'b0;
      cts_sync_reg <= 2'h0;
    end else begin
      tx_low_q     <= tx_low;
      tx_empty_q   <= tx_empty;
      txen_q       <= ier_eff[IER_TXR];
      rts_q        <= RTS_STATE;
      cts_sync_reg <= {cts_sync_reg[0], CTS_N};
      cts_q        <= cts_sync_reg[1];
    end
  end

  logic rts_rise, cts_rise;
  assign rts_rise = RTS_STATE && !rts_q && AUTO_RTS_EN && ier_eff[IER_RTS];
  assign cts_rise = cts_sync_reg[1] && !cts_q && AUTO_CTS_EN && ier_eff[IER_CTS];

  // ---------------------------------------------------------------
  // receive timeout
  // ---------------------------------------------------------------
  uifc_timeout u_timeout (
    .clk         (MCLK),
    .rst_b       (RST_B),
    .bit_tick    (BIT_TICK),
    .char_bits   (CHAR_BITS),
    .rx_nonempty (rx_nonempty),
    .activity    (RX_PUSH || rd_rhr),
    .fire        (tmo_fire)
  );

  // ---------------------------------------------------------------
  // sticky sources; a set in the clearing cycle wins
  // ---------------------------------------------------------------
  logic isr_clr_tx, isr_clr_flow, isr_clr_wake, herr_set;
  assign isr_clr_tx   = rd_isr && (code == CODE_TXR);
  assign isr_clr_flow = rd_isr && (code == CODE_FLOW);
  assign isr_clr_wake = rd_isr && (code == CODE_NONE);
  assign herr_set     = ENH_LSR_EARLY ? (RX_PUSH && (RX_PUSH_ERR != 3'h0))
                                      : (RX_HEAD_ERR != 3'h0);

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ovr_reg  <= 1'b0;
      herr_reg <= 1'b0;
    end else begin
      ovr_reg  <= RX_OVERRUN || (ovr_reg && !rd_lsr);
      herr_reg <= herr_set || (herr_reg && !rd_lsr);
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      tmo_reg <= 1'b0;
      tx_reg  <= 1'b0;
    end else begin
      tmo_reg <= tmo_fire || (tmo_reg && !rd_rhr);
      tx_reg  <= tx_set || (tx_reg && !isr_clr_tx && !wr_thr && ier_eff[IER_TXR]);
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      flow_reg <= 1'b0;
      spec_reg <= 1'b0;
    end else begin
      flow_reg <= FLOW_CHAR_MATCH || (flow_reg && !isr_clr_flow);
      spec_reg <= SPECIAL_MATCH || (spec_reg && !isr_clr_flow && !RX_PUSH);
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      mdelta_reg <= 4'h0;
      hwfc_reg   <= 1'b0;
      wake_reg   <= 1'b0;
    end else begin
      mdelta_reg <= MODEM_DELTA | (mdelta_reg & {4{!rd_msr}});
      hwfc_reg   <= rts_rise || cts_rise || (hwfc_reg && !rd_msr);
      wake_reg   <= (WAKE_EVENT && wake_en_reg && ENH_ENABLE) || (wake_reg && !isr_clr_wake);
    end
  end

  // ---------------------------------------------------------------
  // enabled sources and encoder
  // ---------------------------------------------------------------
  assign act[SRC_LSR]  = ier_eff[IER_LSR] && (ovr_reg || herr_reg);
  assign act[SRC_TMO]  = ier_eff[IER_RXD] && tmo_reg;
  assign act[SRC_RXD]  = ier_eff[IER_RXD] && rxd_lvl;
  assign act[SRC_TXR]  = ier_eff[IER_TXR] && tx_reg;
  assign act[SRC_MDM]  = ier_eff[IER_MDM] && (mdelta_reg != 4'h0);
  assign act[SRC_FLOW] = ier_eff[IER_XOFF] && (flow_reg || spec_reg);
  assign act[SRC_HWFC] = hwfc_reg && (ier_eff[IER_RTS] || ier_eff[IER_CTS]);

  uifc_prio u_prio (
    .act  (act),
    .code (code)
  );

  logic any_act;
  assign any_act = (act != SRC_NONE) || wake_reg;

  // ---------------------------------------------------------------
  // outputs and read data
  // ---------------------------------------------------------------
  logic [7:0] lsr_val, rd_mux;
  assign lsr_val = {RX_FIFO_ERR, tx_empty && TSR_EMPTY, tx_empty,
                    RX_HEAD_ERR, ovr_reg, rx_nonempty};

  always_comb begin
    rd_mux = 8'h00;
    unique case (ADDR)
      OFS_RXTX:    rd_mux = RHR_DATA;
      OFS_IER:     rd_mux = ier_reg;
      OFS_ISR_FCR: rd_mux = {FIFO_EN, FIFO_EN, code};
      OFS_LSR:     rd_mux = lsr_val;
      OFS_MSR:     rd_mux = {MODEM_LINES, mdelta_reg};
      default:     rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      RD_DATA  <= 8'h00;
      INT      <= 1'b0;
      RX_POP   <= 1'b0;
      SLEEP_EN <= 1'b0;
    end else begin
      if (RD_STB) begin
        RD_DATA <= rd_mux;
      end
      INT      <= any_act;
      RX_POP   <= rd_rhr;
      SLEEP_EN <= ier_eff[IER_SLEEP];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_int_request: assert property (@(posedge MCLK) disable iff (!RST_B)
    (any_act |=> INT) and (!any_act |=> !INT))
    else $error("interrupt request does not follow pending sources");

  a_polled_quiet: assert property (@(posedge MCLK) disable iff (!RST_B)
    FIFO_EN && (ier_reg[3:0] == 4'h0) && !ENH_ENABLE && !wake_reg |=> !INT)
    else $error("interrupt raised in polled mode");

  a_isr_format: assert property (@(posedge MCLK) disable iff (!RST_B)
    rd_isr |=> (RD_DATA[7:6] == {2{$past(FIFO_EN)}}) && (RD_DATA[0] == ($past(act) == SRC_NONE)))
    else $error("status read format wrong");

  a_prio_top: assert property (@(posedge MCLK) disable iff (!RST_B)
    rd_isr && act[SRC_LSR] |=> RD_DATA[5:0] == CODE_LSR)
    else $error("line status not reported first");

  a_ier_guard: assert property (@(posedge MCLK) disable iff (!RST_B)
    wr_ier && !ENH_ENABLE |=> ier_reg[7:4] == $past(ier_reg[7:4]))
    else $error("upper enables written without enhanced enable");

  a_qc_ignored: assert property (@(posedge MCLK) disable iff (!RST_B)
    wr_qc && !WR_DATA[QC_EN] |=> !FIFO_EN && !RX_FIFO_RST && !TX_FIFO_RST && $stable(RX_TRIG))
    else $error("queue control bits taken without enable");

  a_rst_selfclr: assert property (@(posedge MCLK) disable iff (!RST_B)
    RX_FIFO_RST || TX_FIFO_RST |=> !RX_FIFO_RST && !TX_FIFO_RST)
    else $error("fifo reset did not clear itself");

  a_trig_map: assert property (@(posedge MCLK) disable iff (!RST_B)
    wr_qc && WR_DATA[QC_EN] |=> RX_TRIG == rx_trig_lvl($past(WR_DATA[7:6])))
    else $error("receive trigger mismatch");

  a_tx_immediate: assert property (@(posedge MCLK) disable iff (!RST_B)
    $rose(ier_eff[IER_TXR]) && tx_low |=> tx_reg)
    else $error("transmit ready not raised on enable");

  a_lsr_clear: assert property (@(posedge MCLK) disable iff (!RST_B)
    rd_lsr && !RX_OVERRUN && !herr_set |=> !ovr_reg && !herr_reg)
    else $error("line status not cleared by read");

  a_msr_clear: assert property (@(posedge MCLK) disable iff (!RST_B)
    rd_msr && !rts_rise && !cts_rise |=> !hwfc_reg)
    else $error("flow change not cleared by modem read");

  c_tx_int:   cover property (@(posedge MCLK) disable iff (!RST_B) rd_isr && code == CODE_TXR);
  c_timeout:  cover property (@(posedge MCLK) disable iff (!RST_B) rd_isr && code == CODE_TMO);
  c_hwfc:     cover property (@(posedge MCLK) disable iff (!RST_B) rd_isr && code == CODE_HWFC);
  c_polled:   cover property (@(posedge MCLK) disable iff (!RST_B) FIFO_EN && rd_lsr && rx_nonempty);

endmodule
`default_nettype wire

// File: uifc_host.sv
// host processor model on the parallel register port
`timescale 1ns/1ps
`default_nettype none
module uifc_host (
  input  wire logic       clk,
  output logic      [2:0] addr,
  output logic            rd_stb,
  output logic            wr_stb,
  output logic      [7:0] wr_data
);
  initial begin
    addr = 3'h0;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    wr_data = 8'h00;
  end

  // one access, strobe held over exactly one taking edge
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wr_data = w ? d : ~wr_data;
    wr_stb = w;
    rd_stb = !w;
    @(posedge clk);
    #1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = ~a;
    wr_data = ~wr_data;
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the interrupt and queue control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import uifc_pkg::*;
();
  logic       mclk, rst_b, rd_stb, wr_stb, tsr_e, push, ovr, ferr, flow, spec, wake, tick, enh, early;
  logic       arts, acts, rts, cts_n, int_o, fifo_en, rxr, txr, pop, sleep;
  logic [2:0] addr, herr, perr;
  logic [3:0] lines, delta, cbits;
  logic [5:0] rx_lvl, tx_lvl, rx_trig, tx_trig;
  logic [7:0] rd_data, receive_holding, wr_data;
  logic [7:0] expq[$];
  logic [7:0] rxt[4] = '{8'h08, 8'h10, 8'h18, 8'h1c};
  logic [7:0] txt[4] = '{8'h10, 8'h08, 8'h18, 8'h1e};
  int         errors, cmp_count, i;
  int         seed = 32'h216ba7fb;

  uifc_host uifc_host_i (.clk(mclk), .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data));
  uifc_ctrl uifc_ctrl_i (.MCLK(mclk), .RST_B(rst_b), .ADDR(addr), .RD_STB(rd_stb), .WR_STB(wr_stb),
    .WR_DATA(wr_data), .RD_DATA(rd_data), .RHR_DATA(receive_holding), .MODEM_LINES(lines), .MODEM_DELTA(delta),
    .RX_LEVEL(rx_lvl), .TX_LEVEL(tx_lvl), .TSR_EMPTY(tsr_e), .RX_HEAD_ERR(herr), .RX_PUSH(push),
    .RX_PUSH_ERR(perr), .RX_OVERRUN(ovr), .RX_FIFO_ERR(ferr), .FLOW_CHAR_MATCH(flow), .SPECIAL_MATCH(spec),
    .WAKE_EVENT(wake), .BIT_TICK(tick), .CHAR_BITS(cbits), .ENH_ENABLE(enh), .ENH_LSR_EARLY(early),
    .AUTO_RTS_EN(arts), .AUTO_CTS_EN(acts), .RTS_STATE(rts), .CTS_N(cts_n), .INT(int_o), .FIFO_EN(fifo_en),
    .RX_FIFO_RST(rxr), .TX_FIFO_RST(txr), .RX_POP(pop), .RX_TRIG(rx_trig), .TX_TRIG(tx_trig), .SLEEP_EN(sleep));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    expq.push_back(e);
    uifc_host_i.acc(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    uifc_host_i.acc(1'b1, a, d);
  endtask

  task automatic wait_int(input logic v);
    int n;
    n = 0;
    while (int_o !== v && n < 10) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({7'h0, int_o}, {7'h0, v});
  endtask

  // read data lands at the taking edge; oldest note is compared
  always @(posedge mclk) begin
    if (rd_stb === 1'b1) begin
      #2;
      chk(rd_data, expq.pop_front());
    end
  end

  initial begin
    #1000000;
    errors++;
    finish_test();
  end

  initial begin
    {tsr_e, push, ovr, ferr, flow, spec, wake, tick, enh, early, arts, acts, rts, cts_n} = '0;
    {herr, perr, lines, delta, rx_lvl, tx_lvl, receive_holding} = '0;
    rst_b = 1'b0;
    tsr_e = 1'b1;
    cbits = 4'ha;
    repeat (5) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    chk({2'h0, rx_trig}, 8'h08);
    chk({2'h0, tx_trig}, 8'h10);
    rd(OFS_ISR_FCR, 8'h01);
    rd(OFS_IER, 8'h00);
    wr(OFS_IER, 8'hff);
    rd(OFS_IER, 8'h0f);
    wr(OFS_IER, 8'h00);
    enh = 1'b1;
    wr(OFS_IER, 8'h10);
    @(posedge mclk);
    #1;
    chk({7'h0, sleep}, 8'h01);
    rd(OFS_IER, 8'h10);
    wr(OFS_IER, 8'h00);
    @(posedge mclk);
    #1;
    chk({7'h0, sleep}, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(OFS_ISR_FCR, {i[1:0], i[1:0], 4'h1});
      chk({2'h0, rx_trig}, rxt[i]);
      chk({2'h0, tx_trig}, txt[i]);
    end
    rd(OFS_ISR_FCR, 8'hc1);
    rx_lvl = 6'h01;
    rd(OFS_LSR, 8'h61);
    chk({7'h0, int_o}, 8'h00);
    wr(OFS_ISR_FCR, 8'h06);
    chk({fifo_en, rxr, rx_trig}, 8'h1c);
    rd(OFS_ISR_FCR, 8'h01);
    wr(OFS_ISR_FCR, 8'h07);
    chk({fifo_en, rxr, txr, 5'h0}, 8'he0);
    @(posedge mclk);
    #1;
    chk({rxr, txr, rx_trig}, 8'h08);
    // receive data and transmit ready pending together
    enh = 1'b0;
    rx_lvl = 6'h08;
    wr(OFS_IER, 8'h07);
    wait_int(1'b1);
    rd(OFS_ISR_FCR, 8'hc4);
    @(posedge mclk);
    #1;
    ovr = 1'b1;
    @(posedge mclk);
    #1;
    ovr = 1'b0;
    repeat (2) @(posedge mclk);
    rd(OFS_ISR_FCR, 8'hc6);
    rd(OFS_LSR, 8'h63);
    rd(OFS_ISR_FCR, 8'hc4);
    rx_lvl = 6'h07;
    rd(OFS_ISR_FCR, 8'hc2);
    rd(OFS_ISR_FCR, 8'hc1);
    wait_int(1'b0);
    // modem delta
    wr(OFS_IER, 8'h08);
    lines = 4'($random(seed));
    delta = 4'h5;
    @(posedge mclk);
    #1;
    delta = 4'h0;
    wait_int(1'b1);
    rd(OFS_ISR_FCR, 8'hc0);
    rd(OFS_MSR, {lines, 4'h5});
    wait_int(1'b0);
    // receive timeout after four characters of ten bits plus twelve bits
    wr(OFS_IER, 8'h01);
    rx_lvl = 6'h01;
    for (i = 0; i < 52; i++) begin
      if (i == 51) chk({7'h0, int_o}, 8'h00);
      @(posedge mclk);
      #1;
      tick = 1'b1;
      @(posedge mclk);
      #1;
      tick = 1'b0;
    end
    wait_int(1'b1);
    rd(OFS_ISR_FCR, 8'hcc);
    receive_holding = 8'($random(seed));
    rd(OFS_RXTX, receive_holding);
    chk({7'h0, pop}, 8'h01);
    rd(OFS_ISR_FCR, 8'hc1);
    repeat (2) @(posedge mclk);
    finish_test();
  end
endmodule
`default_nettype wire
